// ===== rtl/uhpc_params.svh
// Purpose: shared constants of the uart host pin control pair
// Assumes: included by bare name after the package
// Notes: cycle counts derive from the 40 MHz reference clock
`ifndef UHPC_PARAMS_SVH
`define UHPC_PARAMS_SVH

`define UHPC_CLK_HZ 40000000
// pin strobe width on the link, in ns, and in cycles (rounded up)
`define UHPC_STROBE_NS 100
`define UHPC_STROBE_CYC ((`UHPC_STROBE_NS * (`UHPC_CLK_HZ / 1000000) + 999) / 1000)
`define UHPC_STROBE_CW 4

// device register indices on the pin bus
`define UHPC_DEV_INT_MASK 3'h1
`define UHPC_DEV_INT_STAT 3'h2
`define UHPC_DEV_MODEM_CTRL 3'h4
`define UHPC_MODEM_PUSHPULL 5
`define UHPC_MODEM_RING 6
`define UHPC_DEV_EV_RING 0
`define UHPC_DEV_MODEM_RST 8'h00
`define UHPC_DEV_MASK_RST 8'h00
// synchroniser reset: ring pin idles high, so no false edge after reset
`define UHPC_SYNC_RST 3'h4

// host controller registers
`define UHPC_H_CTRL 3'h0
`define UHPC_H_WRITE 3'h1
`define UHPC_H_READ 3'h2
`define UHPC_H_RESULT 3'h3
`define UHPC_H_STAT 3'h4
`define UHPC_H_MASK 3'h5
`define UHPC_CTRL_STYLE 0
`define UHPC_CTRL_RESET 1
`define UHPC_CTRL_SLEEP 2
`define UHPC_CTRL_RST 3'h1
`define UHPC_EV_DONE 0
`define UHPC_EV_DEVIRQ 1
`define UHPC_RES_BUSY 8

`endif

// ===== rtl/uhpc_pkg.sv
// Purpose: types of the uart host pin control pair
// Assumes: nothing
// Notes: states are gray coded along idle, setup, strobe, hold
package uhpc_pkg;
	typedef enum logic [1:0] {
		UHPC_IDLE = 2'h0,
		UHPC_SETUP = 2'h1,
		UHPC_STROBE = 2'h3,
		UHPC_HOLD = 2'h2
	} uhpc_state_t;
endpackage

// ===== rtl/uhpc_if.sv
// Purpose: parallel pin bus between host cpu and uart device
// Assumes: one driver at a time on the data bus
// Notes: resolves the shared data bus and the interrupt pin with its pull
`timescale 1ns/1ps
interface uhpc_if;
	logic bus_style;
	logic cs_n;
	logic [2:0] addr;
	logic bus_read_n;
	logic bus_write_n;
	logic master_reset;
	logic sleep_request;
	logic [7:0] host_dout;
	logic host_doe;
	logic [7:0] dev_dout;
	logic dev_doe;
	logic irq_out;
	logic irq_oe;
	logic [7:0] data;
	logic irq_pin;

	// floating bus reads as all ones
	assign data = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hff);
	// pull-down for open-source mode, pull-up for open-drain mode
	assign irq_pin = irq_oe ? irq_out : ~bus_style;

	modport device (
		input bus_style, cs_n, addr, bus_read_n, bus_write_n, master_reset,
		input sleep_request, data,
		output dev_dout, dev_doe, irq_out, irq_oe
	);
	modport host (
		input data, irq_pin,
		output bus_style, cs_n, addr, bus_read_n, bus_write_n, master_reset,
		output sleep_request, host_dout, host_doe
	);
endinterface

// ===== rtl/uhpc_device.sv
// Purpose: uart device end: bus style decode, reset, sleep, ring, interrupt pin
// Assumes: pin bus inputs other than reset, sleep and ring are synchronous
// Notes: registers are a small subset: mask, sticky status, modem control
// Function
// R1 - strobe style: irq high, push-pull per bit5
// R2 - style pin high selects separate strobes
// R3 - low read strobe means read access
// R4 - direction style ignores read strobe pin
// R5 - low write strobe means write access
// R6 - direction pin high reads, low writes
// R7 - sleep request high stops clock, isolates bus
// R8 - remain asleep while request stays high
// R9 - sleep request falling edge resets registers
// R10 - master reset high or low per style
// R11 - ring active low, rising edge interrupts
// R12 - ring state readable at modem control bit6
// R13 - direction style: irq low, open drain
// R14 - synchronise sleep, reset and ring inputs
`timescale 1ns/1ps
`include "uhpc_params.svh"
module uhpc_device
	import uhpc_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pin bus
	uhpc_if.device bus,
	// modem side
	input wire logic phone_bell_n,
	output logic [DATA_W-1:0] modem_ctrl_out,
	output logic sleeping,
	output logic in_reset
);

	generate
		if (DATA_W != 8 || ADDR_W != 3) begin : g_chk
			$error("uhpc_device serves an 8-bit data, 3-bit address bus only");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// input synchronisers: first stage feeds only the second

	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] async_in;
	localparam logic [2:0] SYNC_RST = `UHPC_SYNC_RST;

	assign async_in = {phone_bell_n, bus.master_reset, bus.sleep_request};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_reg[gi] <= SYNC_RST[gi];
					sync2_reg[gi] <= SYNC_RST[gi];
				end else begin
					sync1_reg[gi] <= async_in[gi]; // [R14]
					sync2_reg[gi] <= sync1_reg[gi]; // [R14]
				end
			end
		end
	endgenerate

	logic sleep_s;
	logic mreset_s;
	logic bell_s;
	logic sleep_d_reg;
	logic bell_d_reg;

	assign sleep_s = sync2_reg[0];
	assign mreset_s = sync2_reg[1];
	assign bell_s = sync2_reg[2];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_d_reg <= 1'b0;
			bell_d_reg <= 1'b1;
		end else begin
			sleep_d_reg <= sleep_s;
			bell_d_reg <= bell_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// style, reset and sleep

	logic strobe_style;
	logic reset_req;
	logic wake_edge;
	logic ring_rise;

	// style pin is driven by the host from its control register style bit, which resets high
	assign strobe_style = bus.bus_style; // [R2]
	assign reset_req = strobe_style ? mreset_s : ~mreset_s; // [R10]
	assign wake_edge = sleep_d_reg & ~sleep_s; // [R9]
	assign ring_rise = bell_s & ~bell_d_reg; // [R11]

	logic soft_rst;
	assign soft_rst = reset_req | wake_edge; // [R9]

	////////////////////////////////////////////////////////////////////////
	// access decode

	logic acc_active;
	logic acc_read;
	logic acc_d_reg;
	logic acc_start;

	always_comb begin
		if (strobe_style) begin
			acc_active = ~bus.cs_n & (~bus.bus_read_n | ~bus.bus_write_n); // [R3] [R5]
			acc_read = ~bus.bus_read_n; // [R3]
		end else begin
			// read strobe pin is not looked at in this style
			acc_active = ~bus.cs_n; // [R4]
			acc_read = bus.bus_write_n; // [R6]
		end
	end

	// sleeping isolates the bus: no access is seen at all
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_d_reg <= 1'b0;
		end else begin
			acc_d_reg <= acc_active & ~sleep_s; // [R7] [R8]
		end
	end

	assign acc_start = acc_active & ~sleep_s & ~acc_d_reg;

	logic wr_take;
	assign wr_take = acc_start & ~acc_read & ~soft_rst; // [R5] [R6]

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] modem_ctrl_reg;
	logic [7:0] mask_reg;
	logic [7:0] stat_reg;
	logic [7:0] stat_next;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			modem_ctrl_reg <= `UHPC_DEV_MODEM_RST;
		end else if (soft_rst) begin
			modem_ctrl_reg <= `UHPC_DEV_MODEM_RST; // [R9] [R10]
		end else if (wr_take && bus.addr == `UHPC_DEV_MODEM_CTRL) begin
			modem_ctrl_reg <= bus.data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= `UHPC_DEV_MASK_RST;
		end else if (soft_rst) begin
			mask_reg <= `UHPC_DEV_MASK_RST; // [R9]
		end else if (wr_take && bus.addr == `UHPC_DEV_INT_MASK) begin
			mask_reg <= bus.data;
		end
	end

	// set wins over write-one-to-clear
	always_comb begin
		stat_next = stat_reg;
		if (wr_take && bus.addr == `UHPC_DEV_INT_STAT) begin
			stat_next = stat_reg & ~bus.data;
		end
		if (ring_rise) begin
			stat_next[`UHPC_DEV_EV_RING] = 1'b1; // [R11]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= 8'h00;
		end else if (soft_rst) begin
			stat_reg <= 8'h00; // [R9]
		end else begin
			stat_reg <= stat_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	logic [7:0] rd_mux;

	always_comb begin
		case (bus.addr)
			`UHPC_DEV_INT_MASK: rd_mux = mask_reg;
			`UHPC_DEV_INT_STAT: rd_mux = stat_reg;
			`UHPC_DEV_MODEM_CTRL: begin
				rd_mux = modem_ctrl_reg;
				rd_mux[`UHPC_MODEM_RING] = ~bell_s; // [R12]
			end
			default: rd_mux = 8'h00;
		endcase
	end

	logic [7:0] dout_reg;
	logic doe_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_reg <= 8'h00;
			doe_reg <= 1'b0;
		end else begin
			dout_reg <= rd_mux;
			doe_reg <= acc_active & acc_read & ~sleep_s; // [R3] [R6] [R7]
		end
	end

	assign bus.dev_dout = dout_reg;
	assign bus.dev_doe = doe_reg;

	////////////////////////////////////////////////////////////////////////
	// interrupt pin

	logic irq_pend;
	logic irq_out_reg;
	logic irq_oe_reg;

	assign irq_pend = |(stat_reg & mask_reg); // [R11]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_out_reg <= 1'b0;
			irq_oe_reg <= 1'b0;
		end else if (strobe_style) begin
			if (modem_ctrl_reg[`UHPC_MODEM_PUSHPULL]) begin
				irq_out_reg <= irq_pend; // [R1]
				irq_oe_reg <= 1'b1; // [R1]
			end else begin
				// open source: drive high only, pull-down gives the low
				irq_out_reg <= 1'b1; // [R1]
				irq_oe_reg <= irq_pend; // [R1]
			end
		end else begin
			irq_out_reg <= 1'b0; // [R13]
			irq_oe_reg <= irq_pend; // [R13]
		end
	end

	assign bus.irq_out = irq_out_reg;
	assign bus.irq_oe = irq_oe_reg;

	////////////////////////////////////////////////////////////////////////
	// user side status

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			modem_ctrl_out <= `UHPC_DEV_MODEM_RST;
			sleeping <= 1'b0;
			in_reset <= 1'b0;
		end else begin
			modem_ctrl_out <= modem_ctrl_reg;
			// oscillator stop is modelled by this flag and the bus isolation
			sleeping <= sleep_s; // [R7] [R8]
			in_reset <= soft_rst;
		end
	end

endmodule

// ===== rtl/uhpc_host.sv
// Purpose: host cpu end: drives pin bus cycles from a simple register port
// Assumes: software writes a command only while the result busy bit is clear
// Notes: commands that arrive while busy are dropped
`timescale 1ns/1ps
`include "uhpc_params.svh"
module uhpc_host
	import uhpc_pkg::*;
#(
	parameter int STROBE_CYC = `UHPC_STROBE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// interrupt
	output logic irq,
	// pin bus
	uhpc_if.host bus
);

	generate
		if (STROBE_CYC < 1 || STROBE_CYC > 15) begin : g_chk
			$error("uhpc_host strobe width must be 1 to 15 cycles");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// control register

	logic [2:0] ctrl_reg;
	logic [7:0] mask_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `UHPC_CTRL_RST;
		end else if (reg_write && reg_addr == `UHPC_H_CTRL) begin
			ctrl_reg <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= 8'h00;
		end else if (reg_write && reg_addr == `UHPC_H_MASK) begin
			mask_reg <= reg_wdata[7:0];
		end
	end

	logic style;
	assign style = ctrl_reg[`UHPC_CTRL_STYLE];

	////////////////////////////////////////////////////////////////////////
	// transfer sequencer

	uhpc_state_t state_reg;
	logic [`UHPC_STROBE_CW-1:0] cnt_reg;
	logic is_read_reg;
	logic [2:0] taddr_reg;
	logic [7:0] tdata_reg;
	logic [7:0] result_reg;
	logic done_pulse;
	logic go_wr;
	logic go_rd;

	assign go_wr = reg_write && reg_addr == `UHPC_H_WRITE && state_reg == UHPC_IDLE;
	assign go_rd = reg_write && reg_addr == `UHPC_H_READ && state_reg == UHPC_IDLE;
	assign done_pulse = state_reg == UHPC_HOLD;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= UHPC_IDLE;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
				UHPC_IDLE: begin
					if (go_wr || go_rd) begin
						state_reg <= UHPC_SETUP;
					end
				end
				UHPC_SETUP: begin
					state_reg <= UHPC_STROBE;
					cnt_reg <= `UHPC_STROBE_CW'(STROBE_CYC - 1);
				end
				UHPC_STROBE: begin
					if (cnt_reg == '0) begin
						state_reg <= UHPC_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				UHPC_HOLD: state_reg <= UHPC_IDLE;
				default: state_reg <= UHPC_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			is_read_reg <= 1'b0;
			taddr_reg <= 3'h0;
			tdata_reg <= 8'h00;
		end else if (go_wr || go_rd) begin
			is_read_reg <= go_rd;
			taddr_reg <= reg_wdata[2:0];
			tdata_reg <= reg_wdata[15:8];
		end
	end

	// sample at the last strobe cycle, when the device has had time to drive
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= 8'h00;
		end else if (state_reg == UHPC_STROBE && cnt_reg == '0 && is_read_reg) begin
			result_reg <= bus.data; // [R3] [R6]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	logic in_cycle;
	logic strobing;
	logic cs_n_reg;
	logic rd_n_reg;
	logic wr_n_reg;
	logic doe_reg;
	logic mr_reg;

	assign in_cycle = state_reg == UHPC_SETUP || state_reg == UHPC_STROBE;
	assign strobing = state_reg == UHPC_STROBE;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			doe_reg <= 1'b0;
			mr_reg <= 1'b0;
		end else begin
			doe_reg <= in_cycle & ~is_read_reg;
			mr_reg <= style ? ctrl_reg[`UHPC_CTRL_RESET] : ~ctrl_reg[`UHPC_CTRL_RESET]; // [R10]
			if (style) begin
				cs_n_reg <= ~in_cycle;
				rd_n_reg <= ~(strobing & is_read_reg); // [R3]
				wr_n_reg <= ~(strobing & ~is_read_reg); // [R5]
			end else begin
				// chip select is the strobe; direction set up a cycle ahead
				cs_n_reg <= ~strobing;
				rd_n_reg <= 1'b1; // [R4]
				wr_n_reg <= in_cycle ? is_read_reg : 1'b1; // [R6]
			end
		end
	end

	assign bus.bus_style = style;
	assign bus.cs_n = cs_n_reg;
	assign bus.addr = taddr_reg;
	assign bus.bus_read_n = rd_n_reg;
	assign bus.bus_write_n = wr_n_reg;
	assign bus.master_reset = mr_reg;
	assign bus.host_dout = tdata_reg;
	assign bus.host_doe = doe_reg;
	assign bus.sleep_request = ctrl_reg[`UHPC_CTRL_SLEEP]; // [R7] [R8]

	////////////////////////////////////////////////////////////////////////
	// events and interrupt

	logic dev_irq;
	logic dev_irq_d_reg;
	logic [7:0] stat_reg;
	logic [7:0] stat_next;

	assign dev_irq = style ? bus.irq_pin : ~bus.irq_pin; // [R1] [R13]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_irq_d_reg <= 1'b0;
		end else begin
			dev_irq_d_reg <= dev_irq;
		end
	end

	always_comb begin
		stat_next = stat_reg;
		if (reg_write && reg_addr == `UHPC_H_STAT) begin
			stat_next = stat_reg & ~reg_wdata[7:0];
		end
		if (done_pulse) begin
			stat_next[`UHPC_EV_DONE] = 1'b1;
		end
		if (dev_irq && !dev_irq_d_reg) begin
			stat_next[`UHPC_EV_DEVIRQ] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= 8'h00;
			irq <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq <= |(stat_next & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			case (reg_addr)
				`UHPC_H_CTRL: reg_rdata <= {13'h0000, ctrl_reg};
				`UHPC_H_WRITE: reg_rdata <= {tdata_reg, 5'h00, taddr_reg};
				`UHPC_H_RESULT: reg_rdata <= {7'h00, state_reg != UHPC_IDLE, result_reg};
				`UHPC_H_STAT: reg_rdata <= {8'h00, stat_reg};
				`UHPC_H_MASK: reg_rdata <= {8'h00, mask_reg};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule

// ===== sim/uhpc_monitor.sv
// Purpose: pin bus checker for the host and device ends
// Assumes: sees the pin bus controls and the device drive enables, not the resolved data bus or irq_pin
// Notes: read access checks wait until sleep and soft reset have been quiet a while
`timescale 1ns/1ps
module uhpc_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pin bus
	input wire logic bus_style,
	input wire logic cs_n,
	input wire logic bus_read_n,
	input wire logic bus_write_n,
	input wire logic master_reset,
	input wire logic sleep_request,
	input wire logic dev_doe,
	input wire logic irq_out,
	input wire logic irq_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////
	// device inputs pass a 2-flop sync, so give it time to settle
	logic [3:0] quiet_cnt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet_cnt <= 4'h0;
		end else if (sleep_request || (master_reset == bus_style)) begin
			quiet_cnt <= 4'h0;
		end else if (quiet_cnt != 4'hf) begin
			quiet_cnt <= quiet_cnt + 4'h1;
		end
	end

	////////////////////////////////////////
	a_strobe_read: assert property (bus_style && quiet_cnt == 4'hf && !cs_n && $fell(bus_read_n)
		|-> ##[1:2] dev_doe) else $error("read strobe not answered");
	a_strobe_write: assert property (bus_style && !bus_write_n && $past(bus_write_n) == 1'b0
		|-> !dev_doe) else $error("device drives during write");
	a_dir_read: assert property (!bus_style && quiet_cnt == 4'hf && bus_write_n && $fell(cs_n)
		|-> ##[1:2] dev_doe) else $error("direction read not answered");
	a_dir_write: assert property (!bus_style && !cs_n && !bus_write_n && $past(cs_n) == 1'b0
		|-> !dev_doe) else $error("device drives during direction write");
	a_sleep_isolates: assert property (sleep_request && $past(sleep_request, 4)
		|-> !dev_doe) else $error("device answers while asleep");
	a_dir_irq_low: assert property (!bus_style && irq_oe |-> !irq_out)
		else $error("direction style interrupt not active low");
	a_mreset_clears: assert property ((master_reset == bus_style) [*5] |-> !irq_oe)
		else $error("interrupt survives master reset");
	a_wake_resets: assert property ($fell(sleep_request) |-> ##8 !irq_oe)
		else $error("interrupt survives wake reset");

	c_wake: cover property ($fell(sleep_request));
	c_dir_irq: cover property (!bus_style && irq_oe);
	c_pushpull: cover property (bus_style && irq_oe && irq_out);
endmodule

// ===== sim/uhpc_bench.sv
// Purpose: self-checking bench of host and device ends joined by the pin bus
// Assumes: default strobe width, software waits for busy to clear
// Notes: device registers reached only through host command and result registers
`timescale 1ns/1ps
`include "uhpc_params.svh"
module uhpc_bench;
	// clock and reset
	logic ref_clk;
	logic rst_n;
	// host register port
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [15:0] reg_rdata;
	logic irq;
	// modem side
	logic phone_bell_n;
	logic sleeping;
	logic [7:0] modem_ctrl_out;
	logic in_reset;
	int fail_count;
	int total_checks;
	logic [15:0] r;
	logic [7:0] q;

	uhpc_if i_uhpc_if();
	uhpc_host i_uhpc_host (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .irq, .bus(i_uhpc_if.host));
	uhpc_device i_uhpc_device (.ref_clk, .rst_n, .bus(i_uhpc_if.device), .phone_bell_n,
		.modem_ctrl_out, .sleeping, .in_reset);
	uhpc_monitor i_uhpc_monitor (.ref_clk, .rst_n, .bus_style(i_uhpc_if.bus_style),
		.cs_n(i_uhpc_if.cs_n), .bus_read_n(i_uhpc_if.bus_read_n),
		.bus_write_n(i_uhpc_if.bus_write_n), .master_reset(i_uhpc_if.master_reset),
		.sleep_request(i_uhpc_if.sleep_request), .dev_doe(i_uhpc_if.dev_doe),
		.irq_out(i_uhpc_if.irq_out), .irq_oe(i_uhpc_if.irq_oe));

	////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic rg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rg_rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic dev_acc(input logic is_rd, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] res);
		logic [15:0] v;
		int n;
		rg_wr(is_rd ? `UHPC_H_READ : `UHPC_H_WRITE, {d, 5'h00, a});
		v = 16'h0100;
		n = 0;
		while (v[`UHPC_RES_BUSY] !== 1'b0 && n < 40) begin
			rg_rd(`UHPC_H_RESULT, v);
			n++;
		end
		res = v[7:0];
		if (v[`UHPC_RES_BUSY] !== 1'b0) begin
			fail_count++;
			close_out();
		end
	endtask

	task automatic ring();
		idle(1);
		phone_bell_n <= 1'b0;
		idle(6);
		phone_bell_n <= 1'b1;
		idle(6);
	endtask

	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		rst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		phone_bell_n = 1'b1;
		fail_count = 0;
		total_checks = 0;
		idle(8);
		rst_n <= 1'b1;
		rg_rd(`UHPC_H_CTRL, r);
		chk("host ctrl", r, 16'h0001);
		rg_rd(3'h7, r);
		chk("unmapped", r, 16'h0000);
		// separate strobes
		dev_acc(1'b0, `UHPC_DEV_INT_MASK, 8'h01, q);
		rg_rd(`UHPC_H_WRITE, r);
		chk("host write reg", r, 16'h0101);
		dev_acc(1'b1, `UHPC_DEV_INT_MASK, 8'h00, q);
		chk("mask", 16'(q), 16'h0001);
		dev_acc(1'b1, `UHPC_DEV_MODEM_CTRL, 8'h00, q);
		chk("modem ctrl idle", 16'(q), 16'h0000);
		idle(1);
		phone_bell_n <= 1'b0;
		idle(6);
		chk("falling ring", 16'(i_uhpc_if.irq_pin), 16'h0000);
		dev_acc(1'b1, `UHPC_DEV_MODEM_CTRL, 8'h00, q);
		chk("modem ctrl ring", 16'(q), 16'h0040);
		idle(1);
		phone_bell_n <= 1'b1;
		idle(6);
		chk("open source", 16'({i_uhpc_if.irq_oe, i_uhpc_if.irq_out}), 16'h0003);
		rg_rd(`UHPC_H_STAT, r);
		chk("host stat", r, 16'h0003);
		chk("masked irq", 16'(irq), 16'h0000);
		rg_wr(`UHPC_H_MASK, 16'h0002);
		idle(2);
		chk("host irq", 16'(irq), 16'h0001);
		rg_rd(`UHPC_H_MASK, r);
		chk("host mask", r, 16'h0002);
		rg_wr(`UHPC_H_STAT, 16'h0003);
		idle(2);
		chk("cleared irq", 16'(irq), 16'h0000);
		dev_acc(1'b0, `UHPC_DEV_MODEM_CTRL, 8'h20, q);
		idle(3);
		chk("push pull", 16'({i_uhpc_if.irq_oe, i_uhpc_if.irq_out}), 16'h0003);
		chk("modem ctrl out", 16'(modem_ctrl_out), 16'h0020);
		// sleep holds off the bus until released, then resets
		rg_wr(`UHPC_H_CTRL, 16'h0005);
		idle(10);
		chk("asleep", 16'(sleeping), 16'h0001);
		dev_acc(1'b1, `UHPC_DEV_MODEM_CTRL, 8'h00, q);
		chk("isolated", 16'(q), 16'h00ff);
		idle(20);
		chk("still asleep", 16'(sleeping), 16'h0001);
		rg_wr(`UHPC_H_CTRL, 16'h0001);
		idle(12);
		chk("awake", 16'(sleeping), 16'h0000);
		chk("wake irq", 16'(i_uhpc_if.irq_pin), 16'h0000);
		dev_acc(1'b1, `UHPC_DEV_MODEM_CTRL, 8'h00, q);
		chk("wake modem ctrl", 16'(q), 16'h0000);
		dev_acc(1'b0, `UHPC_DEV_MODEM_CTRL, 8'h20, q);
		rg_wr(`UHPC_H_CTRL, 16'h0003);
		idle(8);
		chk("reset held", 16'(in_reset), 16'h0001);
		rg_wr(`UHPC_H_CTRL, 16'h0001);
		idle(8);
		chk("reset gone", 16'(in_reset), 16'h0000);
		dev_acc(1'b1, `UHPC_DEV_MODEM_CTRL, 8'h00, q);
		chk("reset high modem ctrl", 16'(q), 16'h0000);
		// direction pin style
		rg_wr(`UHPC_H_CTRL, 16'h0000);
		idle(8);
		dev_acc(1'b0, `UHPC_DEV_INT_MASK, 8'h01, q);
		dev_acc(1'b1, `UHPC_DEV_INT_MASK, 8'h00, q);
		chk("dir mask", 16'(q), 16'h0001);
		chk("read pin", 16'(i_uhpc_if.bus_read_n), 16'h0001);
		ring();
		chk("open drain", 16'({i_uhpc_if.irq_oe, i_uhpc_if.irq_pin}), 16'h0002);
		dev_acc(1'b1, `UHPC_DEV_INT_STAT, 8'h00, q);
		chk("ring status", 16'(q), 16'h0001);
		dev_acc(1'b0, `UHPC_DEV_INT_STAT, 8'h01, q);
		idle(3);
		chk("pull up", 16'(i_uhpc_if.irq_pin), 16'h0001);
		rg_wr(`UHPC_H_CTRL, 16'h0002);
		idle(8);
		rg_wr(`UHPC_H_CTRL, 16'h0000);
		idle(8);
		dev_acc(1'b1, `UHPC_DEV_INT_MASK, 8'h00, q);
		chk("reset low mask", 16'(q), 16'h0000);
		close_out();
	end
endmodule
